// file: common/match_pkg.sv
package match_pkg;

	// Register offsets on the plain register port
	localparam logic [3:0] OFS_CONTROL  = 4'h0;
	localparam logic [3:0] OFS_MASK     = 4'h1;
	localparam logic [3:0] OFS_PATTERN  = 4'h2;
	localparam logic [3:0] OFS_STATUS   = 4'h3;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h4;

	// Control register fields
	localparam int CTL_FLAG_BIT   = 0;
	localparam int CTL_SENSE_BIT  = 1;
	localparam int CTL_ACTIVE_BIT = 2;
	localparam int CTL_IRQ_EN_BIT = 3;

	// Status register fields
	localparam int STS_MATCH_BIT = 0;
	localparam int STS_WAKE_BIT  = 1;

	// Reset values
	localparam logic [7:0] MASK_RST    = 8'h00;
	localparam logic [7:0] PATTERN_RST = 8'hff;
	localparam logic [3:0] CONTROL_RST = 4'h0;

	// Timing: condition must persist more than six cpu clocks
	localparam int HOLD_CYCLES = 6;
	localparam int PERSIST_CNT = HOLD_CYCLES + 1;

	// Power states of the processor
	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_IDLE,
		PWR_DOWN
	} power_e;

	// Register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	// Settings the comparator needs
	typedef struct packed {
		logic [7:0] mask;
		logic [7:0] pattern;
		logic       sense;
	} cmp_cfg_s;

endpackage

// file: hdl/match_persist.sv
`timescale 1ns/1ps

// Compares masked port with pattern and filters short matches
module match_persist
	import match_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int COUNT = PERSIST_CNT
) (
	// Clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             rstn_in,
	// Configuration and port
	input  wire logic             enable_in,
	input  wire cmp_cfg_s         cfg_in,
	input  wire logic [WIDTH-1:0] port_in,
	// Result
	output logic                  hit_out,
	output logic                  cond_out
);

	logic [3:0] run_r;
	logic       cond;

	function automatic logic masked_equal(input logic [7:0] p, input logic [7:0] t,
		input logic [7:0] m);
		masked_equal = ((p ^ t) & m) == 8'h00;
	endfunction

	always_comb begin
		cond = masked_equal(port_in, cfg_in.pattern, cfg_in.mask) ^ cfg_in.sense;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in || !enable_in || !cond) begin
			run_r <= 4'h0;
		end else if (run_r != 4'(COUNT)) begin
			run_r <= run_r + 4'h1;
		end
	end

	// Hit one count before saturation, i.e. condition held > six cycles
	assign hit_out  = enable_in && cond && (run_r >= 4'(COUNT - 1));
	assign cond_out = cond;

	// no hit before seven matching cycles
	short_match_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		hit_out |-> $past(cond_out, 6) && $past(enable_in, 6))
		else $error("hit without persistent match");

endmodule

// file: hdl/pattern_match_interrupt.sv
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps

// Notes on behaviour
// - Per-pin mask selects pins; unselected pins never cause a match.
// - Software-written pattern is compared against the current port value.
// - Sense bit clear means equal, set means not equal.
// - Match flag sets when the condition holds while the function is active.
// - Match interrupt from the flag only when enabled; irq_out still follows status and its mask.
// - Pattern all ones with not-equal sense: any selected low pin matches.
// - Match interrupt wakes the processor from idle and power-down.
// - Flag sets only after the condition persists more than six cycles.
module pattern_match_interrupt
	import match_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             rstn_in,
	// Register port
	input  wire logic [3:0]       addr_in,
	input  wire logic [7:0]       wdata_in,
	input  wire logic             wr_in,
	input  wire logic             rd_in,
	output logic      [7:0]       rdata_out,
	// Port pins and power state
	input  wire logic [WIDTH-1:0] port_in,
	input  wire logic             idle_in,
	input  wire logic             powerdown_in,
	// Interrupt and wake
	output logic                  irq_out,
	output logic                  match_irq_out,
	output logic                  wake_out
);

	reg_req_s   req;
	cmp_cfg_s   cfg;
	power_e     pwr;
	logic [7:0] pin_select_mask_r;
	logic [7:0] match_pattern_r;
	logic       match_flag_r;
	logic       match_sense_select_r;
	logic       active_r;
	logic       irq_en_r;
	logic [1:0] status_r;
	logic [1:0] irq_mask_r;
	logic       hit;
	logic       cond;
	logic       flag_clr;
	logic       wake_evt;
	logic [3:0] run_chk_r;

	// Bundle the port request
	assign req = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};

	function automatic logic sel(input reg_req_s r, input logic [3:0] ofs);
		sel = r.wr && (r.addr == ofs);
	endfunction

	// Power state decode, power-down wins over idle
	always_comb begin
		if (powerdown_in) begin
			pwr = PWR_DOWN;
		end else if (idle_in) begin
			pwr = PWR_IDLE;
		end else begin
			pwr = PWR_RUN;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			pin_select_mask_r <= MASK_RST;
		end else if (sel(req, OFS_MASK)) begin
			pin_select_mask_r <= req.wdata;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			match_pattern_r <= PATTERN_RST;
		end else if (sel(req, OFS_PATTERN)) begin
			match_pattern_r <= req.wdata;
		end
	end

	// Control bits other than the flag
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			match_sense_select_r <= CONTROL_RST[CTL_SENSE_BIT];
			active_r             <= CONTROL_RST[CTL_ACTIVE_BIT];
			irq_en_r             <= CONTROL_RST[CTL_IRQ_EN_BIT];
		end else if (sel(req, OFS_CONTROL)) begin
			match_sense_select_r <= req.wdata[CTL_SENSE_BIT];
			active_r             <= req.wdata[CTL_ACTIVE_BIT];
			irq_en_r             <= req.wdata[CTL_IRQ_EN_BIT];
		end
	end

	// all-ones pattern with not-equal sense falls out of the compare
	assign cfg = '{mask: pin_select_mask_r, pattern: match_pattern_r,
		sense: match_sense_select_r};

	match_persist #(
		.WIDTH (WIDTH),
		.COUNT (PERSIST_CNT)
	) u_persist (
		.clk_sys_in (clk_sys_in),
		.rstn_in    (rstn_in),
		.enable_in  (active_r),
		.cfg_in     (cfg),
		.port_in    (port_in),
		.hit_out    (hit),
		.cond_out   (cond)
	);

	// Software clears the flag by writing zero to its control bit
	assign flag_clr = sel(req, OFS_CONTROL) && !req.wdata[CTL_FLAG_BIT];

	// sticky; set wins over a simultaneous clear
	// A match that lands in the clear cycle is never lost
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			match_flag_r <= CONTROL_RST[CTL_FLAG_BIT];
		end else if (hit) begin
			match_flag_r <= 1'b1;
		end else if (flag_clr) begin
			match_flag_r <= 1'b0;
		end
	end

	assign match_irq_out = match_flag_r && irq_en_r;

	assign wake_evt = match_irq_out && (pwr != PWR_RUN);
	assign wake_out = wake_evt;

	// Sticky status, write one to clear; new events win
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			status_r <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == STS_MATCH_BIT && hit) || (i == STS_WAKE_BIT && wake_evt)) begin
					status_r[i] <= 1'b1;
				end else if (sel(req, OFS_STATUS) && req.wdata[i]) begin
					status_r[i] <= 1'b0;
				end
			end
		end
	end

	// Interrupt mask, same layout as status
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			irq_mask_r <= 2'h0;
		end else if (sel(req, OFS_IRQ_MASK)) begin
			irq_mask_r <= req.wdata[1:0];
		end
	end

	assign irq_out = |(status_r & irq_mask_r);

	// Read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in) begin
			rdata_out <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				OFS_CONTROL:  rdata_out <= {4'h0, irq_en_r, active_r,
					match_sense_select_r, match_flag_r};
				OFS_MASK:     rdata_out <= pin_select_mask_r;
				OFS_PATTERN:  rdata_out <= match_pattern_r;
				OFS_STATUS:   rdata_out <= {6'h00, status_r};
				OFS_IRQ_MASK: rdata_out <= {6'h00, irq_mask_r};
				default:      rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// checker run count
	// Kept apart from the filter so the checks do not reuse its counter
	always_ff @(posedge clk_sys_in) begin
		if (!rstn_in || !active_r || !cond) begin
			run_chk_r <= 4'h0;
		end else if (run_chk_r != 4'hf) begin
			run_chk_r <= run_chk_r + 4'h1;
		end
	end

	unselected_pins_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(active_r && $stable(pin_select_mask_r) && $stable(match_pattern_r) &&
			$stable(match_sense_select_r) &&
			((port_in ^ $past(port_in)) & pin_select_mask_r) == 8'h00) |-> $stable(cond))
		else $error("unselected pin changed condition");

	mask_read_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(rd_in && addr_in == OFS_MASK && !wr_in) |=>
			rdata_out == $past(pin_select_mask_r))
		else $error("mask readback wrong");

	flag_set_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		hit |=> match_flag_r)
		else $error("flag not set after match");

	// flag rises only after seven matching cycles
	flag_persist_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		$rose(match_flag_r) |-> $past(cond, 7) && $past(cond, 1))
		else $error("flag set without persistence");

	flag_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(match_flag_r && !flag_clr) |=> match_flag_r)
		else $error("flag dropped without clear");

	irq_gate_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		match_irq_out |-> (irq_en_r && match_flag_r))
		else $error("irq without enable");

	// wake in low power when irq pending
	wake_low_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(match_irq_out && (idle_in || powerdown_in)) |-> wake_out)
		else $error("no wake in low power");

	equal_sense_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!match_sense_select_r |-> (cond ==
			(((port_in ^ match_pattern_r) & pin_select_mask_r) == 8'h00)))
		else $error("equal sense wrong");

	// keypad mode any selected low pin matches
	keypad_low_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(match_sense_select_r && match_pattern_r == 8'hff &&
			(~port_in & pin_select_mask_r) != 8'h00) |-> cond)
		else $error("keypad low pin missed");

	// read of pattern returns stored value
	pattern_read_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(rd_in && addr_in == OFS_PATTERN && !wr_in) |=> rdata_out == $past(match_pattern_r))
		else $error("pattern readback wrong");

	pattern_write_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(wr_in && addr_in == OFS_PATTERN) |=> match_pattern_r == $past(wdata_in))
		else $error("pattern write lost");

	mask_write_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(wr_in && addr_in == OFS_MASK) |=> pin_select_mask_r == $past(wdata_in))
		else $error("mask write lost");

	not_equal_sense_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		match_sense_select_r |-> (cond ==
			(((port_in ^ match_pattern_r) & pin_select_mask_r) != 8'h00)))
		else $error("not-equal sense wrong");

	sense_read_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(rd_in && addr_in == OFS_CONTROL && !wr_in) |=>
			rdata_out[CTL_SENSE_BIT] == $past(match_sense_select_r))
		else $error("sense readback wrong");

	inactive_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!active_r |=> !$rose(match_flag_r))
		else $error("flag set while inactive");

	status_match_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		hit |=> status_r[STS_MATCH_BIT])
		else $error("match event not recorded");

	ctl_read_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(rd_in && addr_in == OFS_CONTROL && !wr_in) |=>
			rdata_out[CTL_FLAG_BIT] == $past(match_flag_r))
		else $error("flag readback wrong");

	irq_off_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!irq_en_r |-> !match_irq_out)
		else $error("match irq while disabled");

	irq_status_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(status_r[STS_MATCH_BIT] && irq_mask_r[STS_MATCH_BIT]) |-> irq_out)
		else $error("unmasked event without irq");

	irq_en_read_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(rd_in && addr_in == OFS_CONTROL && !wr_in) |=>
			rdata_out[CTL_IRQ_EN_BIT] == $past(irq_en_r))
		else $error("enable readback wrong");

	// in keypad mode all selected pins high never match
	keypad_high_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(match_sense_select_r && match_pattern_r == 8'hff &&
			(~port_in & pin_select_mask_r) == 8'h00) |-> !cond)
		else $error("keypad match with no pin low");

	wake_run_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		!(idle_in || powerdown_in) |-> !wake_out)
		else $error("wake while running");

	wake_status_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		wake_out |=> status_r[STS_WAKE_BIT])
		else $error("wake event not recorded");

	persist_run_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		$rose(match_flag_r) |-> $past(run_chk_r) >= 4'(HOLD_CYCLES))
		else $error("flag rose too early");

	persist_set_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(active_r && cond && run_chk_r == 4'(HOLD_CYCLES)) |=> match_flag_r)
		else $error("persistent match missed");

	flag_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(flag_clr && !hit) |=> !match_flag_r)
		else $error("flag clear ignored");

	status_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
		(wr_in && addr_in == OFS_STATUS && wdata_in[STS_MATCH_BIT] && !hit) |=>
			!status_r[STS_MATCH_BIT])
		else $error("status clear ignored");

endmodule

// file: tb/keypad_model.sv
`timescale 1ns/1ps

// Keypad switches with pull-ups, or an external bus on the pins
module keypad_model (
	// Stimulus from the bench
	input  wire logic [7:0] keys_down_in,
	input  wire logic [7:0] bus_val_in,
	input  wire logic       bus_en_in,
	// Port pins
	output logic      [7:0] pins_out
);
	// bench sets hold time
	// Released keys float to the pull-up level, never the last value
	assign pins_out = bus_en_in ? bus_val_in : ~keys_down_in;
endmodule

// file: tb/tb_pattern_match_interrupt.sv
`timescale 1ns/1ps

// Register-level bench for the pattern match interrupt
module tb_pattern_match_interrupt import match_pkg::*;;
	logic       clk_sys_in   = 1'b0;
	logic       rstn_in      = 1'b0;
	logic [3:0] addr_in      = 4'h0;
	logic [7:0] wdata_in     = 8'h00;
	logic       wr_in        = 1'b0;
	logic       rd_in        = 1'b0;
	logic       idle_in      = 1'b0;
	logic       powerdown_in = 1'b0;
	logic [7:0] keys         = 8'h00;
	logic [7:0] bus_val      = 8'h00;
	logic       bus_en       = 1'b0;
	logic [7:0] port;
	logic [7:0] rdata_out;
	logic       irq_out;
	logic       match_irq_out;
	logic       wake_out;
	int         n_errors        = 0;
	int         samples_checked = 0;

	// Free-running 10 MHz clock
	always #50 clk_sys_in = ~clk_sys_in;

	pattern_match_interrupt dut (
		.clk_sys_in   (clk_sys_in),
		.rstn_in      (rstn_in),
		.addr_in      (addr_in),
		.wdata_in     (wdata_in),
		.wr_in        (wr_in),
		.rd_in        (rd_in),
		.rdata_out    (rdata_out),
		.port_in      (port),
		.idle_in      (idle_in),
		.powerdown_in (powerdown_in),
		.irq_out      (irq_out),
		.match_irq_out(match_irq_out),
		.wake_out     (wake_out)
	);

	keypad_model pins (
		.keys_down_in(keys),
		.bus_val_in  (bus_val),
		.bus_en_in   (bus_en),
		.pins_out    (port)
	);

	// Verdict and end of run
	task automatic report_and_stop;
		if (n_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask

	// One-cycle write strobe; the next call waits a fresh edge
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys_in);
		addr_in  <= a;
		wdata_in <= v;
		wr_in    <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 check(rdata_out, exp);
	endtask

	// Irq, match irq and wake outputs as one bundle
	task automatic outs(input logic [2:0] e);
		#1 check(8'({irq_out, match_irq_out, wake_out}), 8'(e));
	endtask

	task automatic press(input logic [7:0] k, input int n);
		@(posedge clk_sys_in);
		keys <= k;
		cycles(n);
		keys <= 8'h00;
	endtask

	task automatic drive(input logic [7:0] v, input int n);
		@(posedge clk_sys_in);
		bus_en  <= 1'b1;
		bus_val <= v;
		cycles(n);
	endtask

	// Guard against a hang
	initial begin
		cycles(5000);
		n_errors++;
		report_and_stop();
	end

	initial begin
		cycles(12);
		rstn_in <= 1'b1;
		// Reset values and an unmapped place
		rd(OFS_MASK, 8'h00);
		rd(OFS_PATTERN, 8'hff);
		rd(OFS_CONTROL, 8'h00);
		rd(4'h5, 8'h00);
		outs(3'b000);
		// Keypad use: low nibble, not equal, active, irq on
		wr(OFS_MASK, 8'h0f);
		wr(OFS_CONTROL, 8'h0e);
		press(8'h10, 20);
		rd(OFS_CONTROL, 8'h0e);
		press(8'h02, 6);
		rd(OFS_CONTROL, 8'h0e);
		press(8'h02, 7);
		rd(OFS_CONTROL, 8'h0f);
		outs(3'b010);
		wr(OFS_IRQ_MASK, 8'h01);
		outs(3'b110);
		rd(OFS_IRQ_MASK, 8'h01);
		// Wake from idle, then from power-down
		@(posedge clk_sys_in);
		idle_in <= 1'b1;
		outs(3'b111);
		@(posedge clk_sys_in);
		idle_in      <= 1'b0;
		powerdown_in <= 1'b1;
		outs(3'b111);
		@(posedge clk_sys_in);
		powerdown_in <= 1'b0;
		rd(OFS_STATUS, 8'h03);
		wr(OFS_STATUS, 8'h03);
		outs(3'b010);
		rd(OFS_STATUS, 8'h00);
		// Sticky flag, cleared by software, sets again if held
		wr(OFS_CONTROL, 8'h0e);
		rd(OFS_CONTROL, 8'h0e);
		@(posedge clk_sys_in);
		keys <= 8'h01;
		cycles(10);
		wr(OFS_CONTROL, 8'h0e);
		cycles(8);
		rd(OFS_CONTROL, 8'h0f);
		@(posedge clk_sys_in);
		keys <= 8'h00;
		// Equal sense against a bus value
		wr(OFS_MASK, 8'hff);
		wr(OFS_PATTERN, 8'ha5);
		wr(OFS_CONTROL, 8'h0c);
		rd(OFS_PATTERN, 8'ha5);
		drive(8'ha4, 10);
		rd(OFS_CONTROL, 8'h0c);
		drive(8'ha5, 10);
		rd(OFS_CONTROL, 8'h0d);
		// Only selected bits compared; clears land while nothing matches
		wr(OFS_MASK, 8'hf0);
		wr(OFS_PATTERN, 8'ha0);
		drive(8'h53, 1);
		wr(OFS_CONTROL, 8'h0c);
		rd(OFS_CONTROL, 8'h0c);
		drive(8'ha3, 10);
		rd(OFS_CONTROL, 8'h0d);
		drive(8'h53, 1);
		wr(OFS_CONTROL, 8'h0e);
		drive(8'ha3, 10);
		rd(OFS_CONTROL, 8'h0e);
		drive(8'h53, 10);
		rd(OFS_CONTROL, 8'h0f);
		// Inactive function never flags
		drive(8'ha3, 1);
		wr(OFS_STATUS, 8'h03);
		wr(OFS_CONTROL, 8'h0a);
		drive(8'h00, 10);
		rd(OFS_CONTROL, 8'h0a);
		// Irq disabled: no match irq, but status still raises irq_out
		wr(OFS_CONTROL, 8'h06);
		cycles(10);
		rd(OFS_CONTROL, 8'h07);
		outs(3'b100);
		// Mid-run reset, then control and status read back their reset values
		@(posedge clk_sys_in);
		bus_en  <= 1'b0;
		rstn_in <= 1'b0;
		cycles(2);
		outs(3'b000);
		@(posedge clk_sys_in);
		rstn_in <= 1'b1;
		rd(OFS_CONTROL, 8'h00);
		rd(OFS_STATUS, 8'h00);
		report_and_stop();
	end
endmodule
